// ===== core_model.sv
// processor core stand-in that takes the interrupt request
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic irqRequest,
  input wire logic globalMask,
  input wire logic [3:0] latency,
  output logic vectorAck,
  output logic [7:0] taken
);
  // ----
  // vector fetch
  // ----
  logic [3:0] cnt_q;
  always_ff @(posedge clk) begin
    vectorAck <= 1'b0;
    if (rst) begin
      cnt_q <= 4'h0;
      taken <= 8'h0;
    end else if (irqRequest && !globalMask && !vectorAck) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == latency) begin
        vectorAck <= 1'b1;
        cnt_q <= 4'h0;
        taken <= taken + 8'h1;
      end
    end else begin
      cnt_q <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// ===== ext_int_pkg.sv
// constants shared by the external interrupt latch design
package ext_int_pkg;

  // register map, byte addresses
  localparam logic [11:0] ADDR_EXT_INT_STATUS_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_BREAK_FLAG_CONTROL = 12'h004;

  // field positions of ext_int_status_control
  localparam int SENSE_SELECT_ALT_BIT = 0;
  localparam int LOCAL_REQUEST_MASK_BIT = 1;
  localparam int ACK_BIT = 2;
  localparam int REQUEST_PENDING_FLAG_BIT = 3;
  localparam int PIN_LEVEL_BIT = 4;

  // field positions of break_flag_control
  localparam int BREAK_CLEAR_ENABLE_BIT = 0;

  // reset values
  localparam logic SENSE_SELECT_ALT_RST = 1'b0;
  localparam logic LOCAL_REQUEST_MASK_RST = 1'b0;
  localparam logic BREAK_CLEAR_ENABLE_RST = 1'b0;
  localparam logic PIN_SYNC_RST = 1'b1;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // request latch states, gray coded
  typedef enum logic [1:0] {
    LATCH_IDLE = 2'b00,
    LATCH_PENDING = 2'b01,
    LATCH_ACKED = 2'b11
  } latch_state_e;

endpackage

// ===== ext_int_sva.sv
// assertion checker for the external interrupt latch
`timescale 1ns/1ns
`default_nettype none
module ext_int_sva
  import ext_int_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic intPin_n,
  input wire logic vectorAck,
  input wire logic breakActive,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic irqRequest,
  input wire logic pinLevel
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic ctl = pready && paddr == ADDR_EXT_INT_STATUS_CONTROL;
  wire logic wrCtl = ctl && pwrite && pstrb[0];
  a_reset_clears: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> !irqRequest && pinLevel && !pready) else $error("reset state wrong");
  a_pin_level: assert property (
    $stable(intPin_n) [*5] |-> pinLevel == intPin_n) else $error("pin level wrong");
  a_vector_clear: assert property (
    intPin_n [*5] ##0 vectorAck |-> ##2 !irqRequest) else $error("vector ack missed");
  a_soft_ack: assert property (
    intPin_n [*5] ##0 (wrCtl && pwdata[ACK_BIT] && !breakActive) |-> ##2 !irqRequest)
    else $error("ack write missed");
  a_mask_gate: assert property (
    wrCtl && pwdata[LOCAL_REQUEST_MASK_BIT] |-> ##2 !irqRequest) else $error("mask ignored");
  a_ack_zero: assert property (
    ctl && !pwrite |-> prdata[31:5] == 27'h0 && !prdata[ACK_BIT]) else $error("bad read");
  a_rise_cause: assert property (
    $rose(irqRequest) |-> !pinLevel || !$past(pinLevel) || !$past(pinLevel, 2)
    || $past(pready) || $past(pready, 2)) else $error("request without cause");
  a_one_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready) else $error("apb timing wrong");
endmodule
bind external_interrupt_latch ext_int_sva ext_int_sva_i (.clk, .rst, .intPin_n, .vectorAck,
  .breakActive, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .irqRequest, .pinLevel);
`default_nettype wire

// ===== external_interrupt_latch.sv
// external interrupt latch with apb register access
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none

module external_interrupt_latch
  import ext_int_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic intPin_n,
  input wire logic vectorAck,
  input wire logic breakActive,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irqRequest,
  output logic pinLevel
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic pinSync;
  logic pinPrev_q;
  logic pinPrev_d;
  logic fallEdge;
  logic pinHigh;
  logic [2:0] warmUp_q;
  logic [2:0] warmUp_d;
  logic edgeArmed;

  latch_state_e state_q;
  latch_state_e state_d;

  logic senseSelectAlt_q;
  logic senseSelectAlt_d;
  logic localRequestMask_q;
  logic localRequestMask_d;
  logic breakClearEnable_q;
  logic breakClearEnable_d;

  logic ready_q;
  logic ready_d;
  logic slvErr_q;
  logic slvErr_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irqRequest_q;
  logic irqRequest_d;
  logic pinLevel_q;
  logic pinLevel_d;

  logic accessPhase;
  logic commit;
  logic writeCtrl;
  logic writeBreak;
  logic swAck;
  logic anyAck;
  logic pendingNext;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] target);
    reg_hit = (addr == target);
  endfunction

  function automatic logic addr_mapped(input logic [11:0] addr);
    addr_mapped = reg_hit(addr, ADDR_EXT_INT_STATUS_CONTROL)
      || reg_hit(addr, ADDR_BREAK_FLAG_CONTROL);
  endfunction

  function automatic logic is_pending(input latch_state_e st);
    is_pending = (st != LATCH_IDLE);
  endfunction

  function automatic logic [31:0] ctrl_word(input logic mode, input logic mask,
    input logic pending, input logic pin);
    ctrl_word = RDATA_RST;
    ctrl_word[SENSE_SELECT_ALT_BIT] = mode;
    ctrl_word[LOCAL_REQUEST_MASK_BIT] = mask;
    ctrl_word[ACK_BIT] = 1'b0;
    ctrl_word[REQUEST_PENDING_FLAG_BIT] = pending;
    ctrl_word[PIN_LEVEL_BIT] = pin;
  endfunction

  // ----------------------------------------
  // pin synchroniser and edge detect
  // ----------------------------------------
  pin_sync u_pin_sync (
    .clk(clk),
    .rst(rst),
    .pinAsync(intPin_n),
    .pinSync(pinSync)
  );

  always_comb begin
    pinPrev_d = pinSync;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pinPrev_q <= PIN_SYNC_RST;
    end else begin
      pinPrev_q <= pinPrev_d;
    end
  end

  assign fallEdge = pinPrev_q & ~pinSync & edgeArmed;
  assign pinHigh = pinSync;

  // ----------------------------------------
  // edge detect warm-up
  // ----------------------------------------
  // flops reset low and fill with ones: a pin held low through reset is no edge
  always_comb begin
    warmUp_d = {warmUp_q[1:0], 1'b1};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      warmUp_q <= 3'h0;
    end else begin
      warmUp_q <= warmUp_d;
    end
  end

  assign edgeArmed = warmUp_q[2];

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign accessPhase = psel & penable;
  assign commit = accessPhase & ready_q;
  assign writeCtrl = commit & pwrite & pstrb[0] & ~slvErr_q
    & reg_hit(paddr, ADDR_EXT_INT_STATUS_CONTROL);
  assign writeBreak = commit & pwrite & pstrb[0] & ~slvErr_q
    & reg_hit(paddr, ADDR_BREAK_FLAG_CONTROL);

  // software acknowledge, blocked in break unless enabled
  assign swAck = writeCtrl & pwdata[ACK_BIT]
    & (~breakActive | breakClearEnable_q);
  assign anyAck = vectorAck | swAck;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_comb begin
    senseSelectAlt_d = senseSelectAlt_q;
    localRequestMask_d = localRequestMask_q;
    breakClearEnable_d = breakClearEnable_q;
    if (writeCtrl) begin
      senseSelectAlt_d = pwdata[SENSE_SELECT_ALT_BIT];
      localRequestMask_d = pwdata[LOCAL_REQUEST_MASK_BIT];
    end
    if (writeBreak) begin
      breakClearEnable_d = pwdata[BREAK_CLEAR_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      senseSelectAlt_q <= SENSE_SELECT_ALT_RST;
      localRequestMask_q <= LOCAL_REQUEST_MASK_RST;
      breakClearEnable_q <= BREAK_CLEAR_ENABLE_RST;
    end else begin
      senseSelectAlt_q <= senseSelectAlt_d;
      localRequestMask_q <= localRequestMask_d;
      breakClearEnable_q <= breakClearEnable_d;
    end
  end

  // ----------------------------------------
  // request latch
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      LATCH_IDLE: begin
        if (fallEdge) begin
          state_d = LATCH_PENDING;
        end else if (senseSelectAlt_q && !pinHigh) begin
          state_d = LATCH_PENDING;
        end
      end
      LATCH_PENDING: begin
        if (fallEdge) begin
          state_d = LATCH_PENDING;
        end else if (anyAck) begin
          if (!senseSelectAlt_q || pinHigh) begin
            state_d = LATCH_IDLE;
          end else begin
            state_d = LATCH_ACKED;
          end
        end
      end
      LATCH_ACKED: begin
        if (fallEdge) begin
          state_d = LATCH_PENDING;
        end else if (pinHigh || !senseSelectAlt_q) begin
          state_d = LATCH_IDLE;
        end
      end
      default: begin
        state_d = LATCH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= LATCH_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign pendingNext = is_pending(state_d);

  // ----------------------------------------
  // outputs to the core
  // ----------------------------------------
  always_comb begin
    irqRequest_d = pendingNext & ~localRequestMask_d;
    pinLevel_d = pinSync;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqRequest_q <= 1'b0;
      pinLevel_q <= PIN_SYNC_RST;
    end else begin
      irqRequest_q <= irqRequest_d;
      pinLevel_q <= pinLevel_d;
    end
  end

  // ----------------------------------------
  // apb slave, one wait state
  // ----------------------------------------
  always_comb begin
    ready_d = accessPhase & ~ready_q;
    slvErr_d = 1'b0;
    rdata_d = rdata_q;
    if (accessPhase && !ready_q) begin
      slvErr_d = ~addr_mapped(paddr);
      rdata_d = RDATA_RST;
      if (!pwrite && reg_hit(paddr, ADDR_EXT_INT_STATUS_CONTROL)) begin
        rdata_d = ctrl_word(senseSelectAlt_q, localRequestMask_q,
          is_pending(state_q), pinSync);
      end else if (!pwrite && reg_hit(paddr, ADDR_BREAK_FLAG_CONTROL)) begin
        rdata_d[BREAK_CLEAR_ENABLE_BIT] = breakClearEnable_q;
      end
    end else if (commit) begin
      slvErr_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ready_q <= 1'b0;
      slvErr_q <= 1'b0;
      rdata_q <= RDATA_RST;
    end else begin
      ready_q <= ready_d;
      slvErr_q <= slvErr_d;
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = slvErr_q;
  assign irqRequest = irqRequest_q;
  assign pinLevel = pinLevel_q;

endmodule

`default_nettype wire

// ===== pin_sync.sv
// two flip-flop synchroniser for the interrupt pin
`timescale 1ns/1ns
`default_nettype none

module pin_sync
  import ext_int_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pinAsync,
  output logic pinSync
);

  logic stage1_q;
  logic stage1_d;
  logic stage2_q;
  logic stage2_d;

  // ----------------------------------------
  // two stages
  // ----------------------------------------
  always_comb begin
    stage1_d = pinAsync;
    stage2_d = stage1_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_q <= PIN_SYNC_RST;
      stage2_q <= PIN_SYNC_RST;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign pinSync = stage2_q;

endmodule

`default_nettype wire

// ===== test_external_interrupt_latch.sv
// self-checking bench for the external interrupt latch
`timescale 1ns/1ns
`default_nettype none
module test_external_interrupt_latch
  import ext_int_pkg::*;
;
  localparam logic [11:0] C = ADDR_EXT_INT_STATUS_CONTROL;
  localparam logic [11:0] B = ADDR_BREAK_FLAG_CONTROL;
  logic clk, rst, intPin_n, breakActive, psel, penable, pwrite, globalMask, vectorAck;
  logic pready, pslverr, irqRequest, pinLevel, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, latency;
  logic [7:0] taken;
  int failCount = 0;
  int checkCount = 0;
  external_interrupt_latch external_interrupt_latch_i (.clk, .rst, .intPin_n, .vectorAck,
    .breakActive, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .irqRequest, .pinLevel);
  core_model core_model_i (.clk, .rst, .irqRequest, .globalMask, .latency, .vectorAck,
    .taken);
  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic setPin(input logic v);
    @(posedge clk);
    intPin_n <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic doReset();
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    failCount++;
    results();
  end
  // ----
  // sequence
  // ----
  initial begin
    {intPin_n, globalMask} = 2'h3;
    {breakActive, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata, pstrb, latency} = {12'h0, 32'h0, 4'hf, 4'h3};
    doReset();
    rdc(C, 32'h10);
    rdc(B, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, C, 32'h2);
    setPin(1'b0);
    chk(irqRequest, 1'b0);
    rdc(C, 32'ha);
    apb(1'b1, C, 32'h6);
    rdc(C, 32'h2);
    setPin(1'b1);
    setPin(1'b0);
    rdc(C, 32'ha);
    setPin(1'b1);
    apb(1'b1, C, 32'h0);
    repeat (2) @(posedge clk);
    chk(irqRequest, 1'b1);
    chk(taken, 8'h0);
    globalMask <= 1'b0;
    repeat (10) @(posedge clk);
    chk(taken, 8'h1);
    chk(irqRequest, 1'b0);
    globalMask <= 1'b1;
    setPin(1'b1);
    apb(1'b1, C, 32'h1);
    setPin(1'b0);
    apb(1'b1, C, 32'h5);
    repeat (3) @(posedge clk);
    chk(irqRequest, 1'b1);
    apb(1'b1, C, 32'h7);
    repeat (2) @(posedge clk);
    chk(irqRequest, 1'b0);
    rdc(C, 32'hb);
    apb(1'b1, C, 32'h1);
    setPin(1'b1);
    chk(irqRequest, 1'b0);
    setPin(1'b0);
    setPin(1'b1);
    chk(irqRequest, 1'b1);
    apb(1'b1, C, 32'h5);
    repeat (2) @(posedge clk);
    chk(irqRequest, 1'b0);
    setPin(1'b0);
    doReset();
    chk(irqRequest, 1'b0);
    rdc(C, 32'h0);
    setPin(1'b1);
    setPin(1'b0);
    breakActive <= 1'b1;
    apb(1'b1, C, 32'h4);
    repeat (2) @(posedge clk);
    chk(irqRequest, 1'b1);
    apb(1'b1, B, 32'h1);
    apb(1'b1, C, 32'h4);
    breakActive <= 1'b0;
    repeat (2) @(posedge clk);
    chk(irqRequest, 1'b0);
    rdc(B, 32'h1);
    results();
  end
endmodule
`default_nettype wire
